// ---- rtl/power_button_standby_reset_pins.sv ----
`timescale 1ns/1ps
module power_button_standby_reset_pins import pwr_button_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Power button pin and fuses
   input wire logic powerButtonInput,
   input wire logic buttonModeFuse,
   input wire logic [1:0] buttonDebounceFuse,
   input wire logic [1:0] longpressDelayFuse,
   input wire logic [SLOT_W-1:0] hostResetReleaseSlot,
   // Button settings
   input wire logic debounceSelWrite,
   input wire logic [1:0] debounceSelData,
   input wire logic longpressDelayWrite,
   input wire logic [1:0] longpressDelayData,
   input wire logic longpressResetEnable,
   output logic [1:0] buttonDebounceSelect,
   output logic [1:0] longpressResetDelay,
   output logic buttonLevelSense,
   // Interrupt latches
   input wire logic [IRQ_N-1:0] irqMask,
   input wire logic [IRQ_N-1:0] irqClear,
   output logic [IRQ_N-1:0] irqStatus,
   // Standby pin
   input wire logic standbyInput,
   input wire logic standbyPolarityInvert,
   // Sequencer status
   output logic systemOn,
   output logic standbyMode,
   output logic powerUpBusy,
   output logic powerDownBusy,
   // Open-drain host reset pin
   input wire logic hostResetInN,
   output logic hostResetOutN,
   output logic hostResetOe,
   // Open-drain interrupt pin
   input wire logic irqInN,
   output logic irqOutN,
   output logic irqOutOe
);
   // ==========================================================
   // State
   typedef struct packed {
      seq_state_t state;
      logic [SLOT_W-1:0] slot;
      logic [DISCH_W-1:0] disch;
      logic restart;
      logic hostRstOe;
      logic [IRQ_N-1:0] irq;
      logic [1:0] dbSel;
      logic [1:0] lpDelay;
      logic loaded;
      logic sense;
      logic [TIME_W-1:0] holdMs;
   } core_t;

   localparam core_t CORE_RST = '{state: ST_OFF, slot: '0, disch: '0, restart: 1'b0, hostRstOe: 1'b1,
                                  irq: '0, dbSel: '0, lpDelay: '0, loaded: 1'b0, sense: 1'b0, holdMs: '0};

   core_t q, d;
   logic tick;
   logic btnLevel;
   logic btnChanged;
   logic pressEvt;
   logic releaseEvt;
   logic longEvt;
   logic stbyActive;
   logic levelOff;

   // ==========================================================
   // Common timebase and debounce
   tick_divider #(.DIV(TICK_CYCLES)) u_tick (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tick(tick)
   );

   button_debounce u_db (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tick(tick),
      .fallMs(dbFallMs(q.dbSel)),
      .riseMs(DB_SHORT_MS),
      .rawLevel(powerButtonInput),
      .level(btnLevel),
      .changed(btnChanged)
   );

   // ==========================================================
   // Next state
   always_comb begin
      d = q;
      pressEvt = btnChanged && !btnLevel;
      releaseEvt = btnChanged && btnLevel;
      longEvt = tick && !btnLevel && !btnChanged && (q.holdMs == lpDelayMs(q.lpDelay));
      stbyActive = standbyInput ^ standbyPolarityInvert;
      levelOff = !buttonModeFuse && !btnLevel;
      d.sense = powerButtonInput;
      d.loaded = 1'b1;

      // Fuse straps are caught on the first clock after reset release
      if (!q.loaded) begin
         d.dbSel = buttonDebounceFuse;
         d.lpDelay = longpressDelayFuse;
      end else begin
         if (debounceSelWrite) begin
            d.dbSel = debounceSelData;
         end
         if (longpressDelayWrite) begin
            d.lpDelay = longpressDelayData;
         end
      end

      // Clear first so that a same-cycle event wins
      d.irq = q.irq & ~irqClear;

      if (btnChanged) begin
         d.holdMs = '0;
      end else if (tick && !btnLevel && (q.holdMs != '1)) begin
         d.holdMs = q.holdMs + 1'b1;
      end

      // Equality on the count makes each hold interrupt fire once per press
      for (int i = 0; i < HOLD_N; i++) begin
         if (tick && !btnLevel && !btnChanged && (q.holdMs == HOLD_MS[i])) begin
            d.irq[IRQ_HOLD1 + i] = 1'b1;
         end
      end

      if (q.state == ST_ON) begin
         if (pressEvt) begin
            d.irq[IRQ_PRESS] = 1'b1;
         end
         if (releaseEvt) begin
            d.irq[IRQ_RELEASE] = 1'b1;
         end
      end

      unique case (q.state)
         ST_OFF: begin
            d.hostRstOe = 1'b1;
            // Edge mode needs a fresh debounced press; level mode needs a high level.
            // The filtered level starts released, so level mode also checks the raw pin;
            // otherwise a pin held low through reset would power up briefly.
            if (buttonModeFuse ? pressEvt : (btnLevel && powerButtonInput)) begin
               d.state = ST_PWRUP;
               d.slot = '0;
               if (pressEvt) begin
                  d.irq[IRQ_PRESS] = 1'b1;
               end
            end
         end
         ST_PWRUP: begin
            if (levelOff) begin
               d.state = ST_PWRDN;
               d.slot = '0;
               d.restart = 1'b0;
            end else if (tick) begin
               if (q.slot == hostResetReleaseSlot) begin
                  d.hostRstOe = 1'b0;
                  d.state = ST_ON;
               end else begin
                  d.slot = q.slot + 1'b1;
               end
            end
         end
         ST_ON, ST_STBY: begin
            if (levelOff || longEvt) begin
               d.state = ST_PWRDN;
               d.slot = '0;
               d.hostRstOe = 1'b1;
               d.restart = !levelOff && longpressResetEnable;
            end else if (q.state == ST_ON && stbyActive) begin
               d.state = ST_STBY;
            end else if (q.state == ST_STBY && !stbyActive) begin
               d.state = ST_ON;
            end
         end
         ST_PWRDN: begin
            d.hostRstOe = 1'b1;
            if (tick) begin
               if (q.slot == PDN_LAST_SLOT) begin
                  d.state = q.restart ? ST_DISCH : ST_OFF;
                  d.disch = '0;
               end else begin
                  d.slot = q.slot + 1'b1;
               end
            end
         end
         ST_DISCH: begin
            if (q.disch == DISCHARGE_CYCLES - 1'b1) begin
               d.state = ST_PWRUP;
               d.slot = '0;
               d.restart = 1'b0;
               d.dbSel = buttonDebounceFuse;
               d.lpDelay = longpressDelayFuse;
            end else begin
               d.disch = q.disch + 1'b1;
            end
         end
         default: begin
            d.state = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q <= CORE_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign buttonDebounceSelect = q.dbSel;
   assign longpressResetDelay = q.lpDelay;
   assign buttonLevelSense = q.sense;
   assign irqStatus = q.irq;
   assign systemOn = (q.state == ST_ON);
   assign standbyMode = (q.state == ST_STBY);
   assign powerUpBusy = (q.state == ST_PWRUP);
   assign powerDownBusy = (q.state == ST_PWRDN) || (q.state == ST_DISCH);
   // Open-drain pins only ever drive low; the pad reads back are not needed here
   assign hostResetOutN = 1'b0;
   assign hostResetOe = q.hostRstOe;
   assign irqOutN = 1'b0;
   assign irqOutOe = |(q.irq & ~irqMask);

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_level_mode_off: assert property ((!buttonModeFuse && !btnLevel && systemOn) |=> !systemOn)
      else $error("level mode stayed on with button low");
   a_level_poweron_high: assert property (($rose(powerUpBusy) && !buttonModeFuse) |-> $past(btnLevel))
      else $error("power-on without high button level");
   a_edge_needs_press: assert property (($rose(powerUpBusy) && buttonModeFuse && $past(q.state == ST_OFF))
      |-> $past(pressEvt))
      else $error("edge mode power-on without debounced press");
   a_sense_tracks_pin: assert property (##1 (!$past(reset_n) || buttonLevelSense == $past(powerButtonInput)))
      else $error("level sense does not follow pin");
   a_press_irq_cause: assert property (($rose(q.irq[IRQ_PRESS])) |-> $past(pressEvt))
      else $error("press interrupt without debounced press");
   a_release_irq_on: assert property (($rose(q.irq[IRQ_RELEASE])) |-> $past(systemOn) && btnLevel)
      else $error("release interrupt outside On state");
   a_hold_one_count: assert property (($rose(q.irq[IRQ_HOLD1])) |-> $past(q.holdMs) == HOLD_MS[0])
      else $error("one second hold fired at wrong count");
   a_hold_eight_count: assert property (($rose(q.irq[IRQ_HOLD1 + 4])) |-> $past(q.holdMs) == HOLD_MS[4])
      else $error("eight second hold fired at wrong count");
   a_long_reset_path: assert property (($past(longEvt) && $past(systemOn || standbyMode) && $past(!levelOff))
      |-> (q.state == ST_PWRDN) && (q.restart == $past(longpressResetEnable)))
      else $error("long press did not start the selected power-down");
   a_disch_holds_reset: assert property ((q.state == ST_DISCH) |-> hostResetOe && !systemOn)
      else $error("host reset released during discharge");
   a_standby_polarity: assert property ($rose(standbyMode) |-> $past(standbyInput ^ standbyPolarityInvert))
      else $error("standby entered with inactive pin");
   a_on_reset_free: assert property (systemOn |-> !hostResetOe)
      else $error("host reset asserted in On state");
   a_down_asserts_rst: assert property ($rose(powerDownBusy) |-> hostResetOe)
      else $error("power-down began with host reset released");
   a_clear_wins_late: assert property ((irqClear[IRQ_RELEASE] && !releaseEvt) |=> !q.irq[IRQ_RELEASE])
      else $error("release latch not cleared by write");

   c_reach_on: cover property ($rose(systemOn));
   c_long_reset: cover property (q.state == ST_DISCH ##1 q.state == ST_PWRUP);
   c_standby: cover property ($rose(standbyMode));
   c_hold_eight: cover property ($rose(q.irq[IRQ_HOLD1 + 4]));
endmodule

// ---- shared/pwr_button_pkg.sv ----
package pwr_button_pkg;
   // ==========================================================
   // Clock and timebase
   localparam int CLK_HZ = 20_000_000;
   localparam int TIMEBASE_MS = 1;
   localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TIMEBASE_MS;
   localparam int DISCHARGE_US = 30;
   localparam int DISCHARGE_CYCLES_I = (DISCHARGE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int DISCH_W = 10;
   localparam logic [DISCH_W-1:0] DISCHARGE_CYCLES = DISCH_W'(DISCHARGE_CYCLES_I);

   // ==========================================================
   // Millisecond thresholds
   localparam int TIME_W = 15;
   localparam logic [TIME_W-1:0] DB_SHORT_MS = 15'h0020;
   localparam logic [TIME_W-1:0] DB_MID_MS = 15'h007D;
   localparam logic [TIME_W-1:0] DB_LONG_MS = 15'h02EE;
   localparam int HOLD_N = 5;
   localparam logic [TIME_W-1:0] HOLD_MS [HOLD_N] = '{15'h03E8, 15'h07D0, 15'h0BB8, 15'h0FA0, 15'h1F40};
   localparam logic [TIME_W-1:0] LP_2S_MS = 15'h07D0;
   localparam logic [TIME_W-1:0] LP_4S_MS = 15'h0FA0;
   localparam logic [TIME_W-1:0] LP_8S_MS = 15'h1F40;
   localparam logic [TIME_W-1:0] LP_16S_MS = 15'h3E80;

   // ==========================================================
   // Sequencer
   localparam int SLOT_W = 8;
   localparam logic [SLOT_W-1:0] PDN_LAST_SLOT = 8'h07;

   // ==========================================================
   // Interrupt latch positions
   localparam int IRQ_N = 7;
   localparam int IRQ_PRESS = 0;
   localparam int IRQ_RELEASE = 1;
   localparam int IRQ_HOLD1 = 2;

   localparam logic [1:0] SEL_MID = 2'h2;
   localparam logic [1:0] SEL_LONG = 2'h3;

   typedef enum logic [2:0] {ST_OFF, ST_PWRUP, ST_ON, ST_STBY, ST_PWRDN, ST_DISCH} seq_state_t;

   function automatic logic [TIME_W-1:0] dbFallMs(input logic [1:0] sel);
      unique case (sel)
         SEL_MID: dbFallMs = DB_MID_MS;
         SEL_LONG: dbFallMs = DB_LONG_MS;
         default: dbFallMs = DB_SHORT_MS;
      endcase
   endfunction

   function automatic logic [TIME_W-1:0] lpDelayMs(input logic [1:0] sel);
      unique case (sel)
         2'h0: lpDelayMs = LP_2S_MS;
         2'h1: lpDelayMs = LP_4S_MS;
         SEL_MID: lpDelayMs = LP_8S_MS;
         default: lpDelayMs = LP_16S_MS;
      endcase
   endfunction
endpackage

// ---- rtl/tick_divider.sv ----
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 20000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Timebase
   output logic tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } div_t;

   div_t q, d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == CW'(DIV - 1)) begin
         d.cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule

// ---- rtl/button_debounce.sv ----
`timescale 1ns/1ps
module button_debounce import pwr_button_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Timebase and thresholds in ticks
   input wire logic tick,
   input wire logic [TIME_W-1:0] fallMs,
   input wire logic [TIME_W-1:0] riseMs,
   // Button
   input wire logic rawLevel,
   output logic level,
   output logic changed
);
   typedef struct packed {
      logic level;
      logic changed;
      logic [TIME_W-1:0] cnt;
   } db_t;

   db_t q, d;
   logic [TIME_W-1:0] thr;

   always_comb begin
      d = q;
      d.changed = 1'b0;
      thr = rawLevel ? riseMs : fallMs;
      // A bounce back to the held level throws away the partial count
      if (rawLevel == q.level) begin
         d.cnt = '0;
      end else if (tick) begin
         if (q.cnt >= thr) begin
            d.level = rawLevel;
            d.changed = 1'b1;
            d.cnt = '0;
         end else begin
            d.cnt = q.cnt + 1'b1;
         end
      end
   end

   // Filtered level starts released so a held button is seen as a fresh press
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{level: 1'b1, changed: 1'b0, cnt: '0};
      end else begin
         q <= d;
      end
   end

   assign level = q.level;
   assign changed = q.changed;
endmodule

// ---- tb/button_partner.sv ----
`timescale 1ns/1ps
module button_partner #(
   parameter int BOUNCE = 4
) (
   // Clock
   input wire logic clk_sys,
   // Bench command, 1 = button held down
   input wire logic pressReq,
   // Button pin
   output logic buttonPin,
   // Open-drain pins
   input wire logic hostResetOe,
   input wire logic irqOutOe,
   output logic hostResetLine,
   output logic irqLine,
   output logic hostInReset
);
   // ==========================================================
   // Push button with contact bounce
   logic lastReq = 1'b0;
   int bounceLeft = 0;

   initial buttonPin = 1'b1;

   // Bounce makes the pin chatter so a naive edge detector would misfire
   always @(posedge clk_sys) begin
      if (pressReq != lastReq) begin
         lastReq <= pressReq;
         bounceLeft <= BOUNCE;
      end
      if (bounceLeft > 0) begin
         bounceLeft <= bounceLeft - 1;
         buttonPin <= ~buttonPin;
      end else begin
         buttonPin <= ~lastReq;
      end
   end

   // ==========================================================
   // Pull-ups on the open-drain lines
   assign hostResetLine = hostResetOe ? 1'b0 : 1'b1;
   assign hostInReset = ~hostResetLine;
   assign irqLine = irqOutOe ? 1'b0 : 1'b1;
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb import pwr_button_pkg::*;;
   localparam int TC = 2;
   localparam int HOLD_T [5] = '{1000, 2000, 3000, 4000, 8000};
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic pressReq = 1'b0;
   logic buttonModeFuse = 1'b1;
   logic [1:0] buttonDebounceFuse = 2'h2;
   logic [1:0] longpressDelayFuse = 2'h1;
   logic [SLOT_W-1:0] hostResetReleaseSlot = 8'h05;
   logic debounceSelWrite = 1'b0;
   logic [1:0] debounceSelData = 2'h0;
   logic longpressDelayWrite = 1'b0;
   logic [1:0] longpressDelayData = 2'h0;
   logic longpressResetEnable = 1'b0;
   logic [IRQ_N-1:0] irqMask = 7'h7F;
   logic [IRQ_N-1:0] irqClear = 7'h00;
   logic standbyInput = 1'b0;
   logic standbyPolarityInvert = 1'b0;
   logic powerButtonInput, hostResetLine, irqLine, hostInReset;
   logic [1:0] buttonDebounceSelect, longpressResetDelay;
   logic [IRQ_N-1:0] irqStatus;
   logic buttonLevelSense, systemOn, standbyMode, powerUpBusy, powerDownBusy, hostResetOe, irqOutOe;
   int failures = 0;
   int checksDone = 0;
   int elapsed = 0;

   always #25 clk_sys = ~clk_sys;

   // Short tick so the 16 s range fits in a short run
   power_button_standby_reset_pins #(.TICK_CYCLES(TC)) dut_u (
      .clk_sys, .reset_n, .powerButtonInput, .buttonModeFuse, .buttonDebounceFuse,
      .longpressDelayFuse, .hostResetReleaseSlot, .debounceSelWrite, .debounceSelData,
      .longpressDelayWrite, .longpressDelayData, .longpressResetEnable,
      .buttonDebounceSelect, .longpressResetDelay, .buttonLevelSense, .irqMask, .irqClear,
      .irqStatus, .standbyInput, .standbyPolarityInvert, .systemOn, .standbyMode,
      .powerUpBusy, .powerDownBusy, .hostResetInN(hostResetLine), .hostResetOutN(),
      .hostResetOe, .irqInN(irqLine), .irqOutN(), .irqOutOe);

   button_partner partner_u (.clk_sys, .pressReq, .buttonPin(powerButtonInput),
      .hostResetOe, .irqOutOe, .hostResetLine, .irqLine, .hostInReset);

   // ==========================================================
   // Access tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic checkBit(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic press(input logic v);
      @(posedge clk_sys);
      pressReq <= v;
      elapsed = 0;
   endtask

   // Waits until the given tick count since the last press or resetDut call
   task automatic waitT(input int target);
      repeat ((target - elapsed) * TC) @(negedge clk_sys);
      elapsed = target;
   endtask

   task automatic waitUntil(input logic sel, input logic want, input int maxCyc);
      int n;
      n = 0;
      while ((sel ? powerDownBusy : systemOn) !== want && n < maxCyc) begin
         @(negedge clk_sys);
         n++;
      end
      checkBit(sel ? powerDownBusy : systemOn, want);
   endtask

   task automatic writeSel(input logic toDelay, input logic [1:0] v);
      @(posedge clk_sys);
      debounceSelWrite <= ~toDelay;
      longpressDelayWrite <= toDelay;
      debounceSelData <= v;
      longpressDelayData <= v;
      @(posedge clk_sys);
      debounceSelWrite <= 1'b0;
      longpressDelayWrite <= 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic clearIrq(input logic [IRQ_N-1:0] m);
      @(posedge clk_sys);
      irqClear <= m;
      @(posedge clk_sys);
      irqClear <= 7'h00;
      @(negedge clk_sys);
   endtask

   task automatic resetDut(input logic mode);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      buttonModeFuse <= mode;
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(negedge clk_sys);
      elapsed = 0;
   endtask

   task automatic conclude();
      $display("Checks done %0d, failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      resetDut(1'b1);
      check({14'h0000, buttonDebounceSelect}, 16'h0002);
      check({14'h0000, longpressResetDelay}, 16'h0001);
      checkBit(hostInReset, 1'b1);
      // A press shorter than the 125 ms falling filter must not start power-up
      press(1'b1);
      waitT(3);
      checkBit(buttonLevelSense, 1'b0);
      waitT(100);
      press(1'b0);
      waitT(3);
      checkBit(buttonLevelSense, 1'b1);
      waitT(60);
      checkBit(powerUpBusy | systemOn, 1'b0);
      press(1'b1);
      waitT(122);
      checkBit(powerUpBusy, 1'b0);
      waitT(134);
      checkBit(irqStatus[IRQ_PRESS], 1'b1);
      waitUntil(1'b0, 1'b1, 40 * TC);
      checkBit(hostResetOe, 1'b0);
      // Rising filter stays 32 ms whatever the select
      press(1'b0);
      waitT(30);
      checkBit(irqStatus[IRQ_RELEASE], 1'b0);
      waitT(40);
      checkBit(irqStatus[IRQ_RELEASE], 1'b1);
      @(posedge clk_sys);
      irqMask <= 7'h7E;
      @(negedge clk_sys);
      checkBit(irqLine, 1'b0);
      clearIrq(7'h01);
      checkBit(irqStatus[IRQ_RELEASE], 1'b1);
      checkBit(irqLine, 1'b1);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         standbyInput <= k[0];
         standbyPolarityInvert <= k[1];
         repeat (6) @(negedge clk_sys);
         checkBit(standbyMode, k[0] ^ k[1]);
         checkBit(systemOn, ~(k[0] ^ k[1]));
      end
      writeSel(1'b0, 2'h3);
      writeSel(1'b1, 2'h2);
      check({14'h0000, buttonDebounceSelect}, 16'h0003);
      check({14'h0000, longpressResetDelay}, 16'h0002);
      clearIrq(7'h7F);
      press(1'b1);
      waitT(745);
      checkBit(irqStatus[IRQ_PRESS], 1'b0);
      waitT(760);
      checkBit(irqStatus[IRQ_PRESS], 1'b1);
      for (int k = 0; k < 5; k++) begin
         waitT(748 + HOLD_T[k]);
         checkBit(irqStatus[IRQ_HOLD1 + k], 1'b0);
         checkBit(systemOn & ~hostResetOe, 1'b1);
         waitT(758 + HOLD_T[k]);
         checkBit(irqStatus[IRQ_HOLD1 + k], 1'b1);
      end
      checkBit(systemOn, 1'b0);
      checkBit(powerDownBusy & hostResetOe, 1'b1);
      waitT(8790);
      checkBit(powerDownBusy | powerUpBusy | systemOn, 1'b0);
      // Long press with restart; button stays down through power-up
      writeSel(1'b1, 2'h0);
      @(posedge clk_sys);
      longpressResetEnable <= 1'b1;
      press(1'b0);
      waitT(40);
      press(1'b1);
      waitT(770);
      checkBit(systemOn, 1'b1);
      waitT(2745);
      checkBit(systemOn, 1'b1);
      waitT(2756);
      checkBit(powerDownBusy & hostResetOe, 1'b1);
      press(1'b0);
      // Power-down and discharge both count as busy, so it is still high here
      waitUntil(1'b1, 1'b1, 20 * TC);
      repeat (560) @(negedge clk_sys);
      checkBit(powerUpBusy | systemOn, 1'b0);
      waitUntil(1'b0, 1'b1, 100 * TC);
      check({14'h0000, buttonDebounceSelect}, 16'h0002);
      check({14'h0000, longpressResetDelay}, 16'h0001);
      // Level mode with the pin held low
      press(1'b1);
      resetDut(1'b0);
      waitT(200);
      checkBit(systemOn | powerUpBusy, 1'b0);
      waitT(300);
      checkBit(systemOn | ~hostResetOe, 1'b0);
      press(1'b0);
      waitT(50);
      checkBit(systemOn, 1'b1);
      press(1'b1);
      waitT(140);
      checkBit(systemOn, 1'b0);
      conclude();
   end

   // Tests take about 26000 clocks
   initial begin
      #(60000 * 50);
      failures++;
      conclude();
   end
endmodule
